/* File: hdl/sbt_pkg.sv */
// constants and types shared by the memory test access port
package sbt_pkg;
	localparam int IR_W = 3; // instruction register width
	localparam int ID_W = 32; // identification register width
	localparam logic [IR_W-1:0] IR_CAPT = 3'h1; // capture pattern, low bits 01
	localparam logic [IR_W-1:0] IR_IDCODE = 3'h1; // identification instruction
	localparam logic [IR_W-1:0] IR_BYPASS = 3'h7; // bypass instruction
	localparam logic [ID_W-1:0] ID_VALUE = 32'h0000_0001; // arbitrary value, bit 0 set
	localparam int SYNC_N = 3; // flops in the core-side synchroniser
	localparam logic [0:0] BYP_CAPT = 1'h0; // bypass cell capture value
	// one-hot controller states
	typedef enum logic [15:0] {
		ST_TLR = 16'h0001,
		ST_RTI = 16'h0002,
		ST_SEL_DR = 16'h0004,
		ST_CAP_DR = 16'h0008,
		ST_SH_DR = 16'h0010,
		ST_EX1_DR = 16'h0020,
		ST_PA_DR = 16'h0040,
		ST_EX2_DR = 16'h0080,
		ST_UPD_DR = 16'h0100,
		ST_SEL_IR = 16'h0200,
		ST_CAP_IR = 16'h0400,
		ST_SH_IR = 16'h0800,
		ST_EX1_IR = 16'h1000,
		ST_PA_IR = 16'h2000,
		ST_EX2_IR = 16'h4000,
		ST_UPD_IR = 16'h8000
	} sbt_state_t;
endpackage : sbt_pkg

/* File: hdl/sbt_tap.sv */
// boundary scan test access port of the memory, on its own test clock
//
// Summary of operation
// - follow the standard boundary scan state machine
// - sample all test inputs on rising edge
// - change test output only on falling edge
// - unconnected mode-select and data-in read high
// - instruction selects register between input and output
// - serial data enters selected register's top bit
// - output shows selected register's bottom bit
// - output driver enabled only in shift states
// - five mode-select-high edges force test reset
// - test reset never disturbs memory operation
// - power up resets port, output undriven
// - three-bit instruction, update loads, reset gives identify
// - instruction capture loads 01 in low bits
// - bypass is one bit in data shift
// - identify captures fixed 32-bit code, shifts out
`timescale 1ns/10ps
module sbt_tap
	import sbt_pkg::*;
(
	input wire logic core_clk_i, // memory core clock
	input wire logic nrst_i, // power-up reset, active low
	input wire logic test_clk_i, // test clock from the board controller
	input wire logic tms_i, // mode select level when driven
	input wire logic tms_drv_i, // high while the board drives mode select
	input wire logic tdi_i, // serial data in when driven
	input wire logic tdi_drv_i, // high while the board drives data in
	output logic tdo_o, // serial data out
	output logic tdo_oe_o, // high while the port drives data out
	output logic [IR_W-1:0] ir_o, // current instruction
	output logic tap_reset_o // port in test reset, core clock domain
);
	// pull-ups resolve at the pad: an undriven pin reads high
	logic tms_eff; // effective mode select
	logic tdi_eff; // effective data in
	assign tms_eff = tms_drv_i ? tms_i : 1'b1;
	assign tdi_eff = tdi_drv_i ? tdi_i : 1'b1;

	sbt_state_t state_r; // controller state
	sbt_state_t state_nxt; // next controller state

	// controller next state; every state leaves on the mode select alone
	always_comb begin
		state_nxt = state_r;
		case (state_r)
			ST_TLR: begin
				state_nxt = tms_eff ? ST_TLR : ST_RTI;
			end
			ST_RTI: begin
				state_nxt = tms_eff ? ST_SEL_DR : ST_RTI;
			end
			ST_SEL_DR: begin
				state_nxt = tms_eff ? ST_SEL_IR : ST_CAP_DR;
			end
			ST_CAP_DR: begin
				state_nxt = tms_eff ? ST_EX1_DR : ST_SH_DR;
			end
			ST_SH_DR: begin
				state_nxt = tms_eff ? ST_EX1_DR : ST_SH_DR;
			end
			ST_EX1_DR: begin
				state_nxt = tms_eff ? ST_UPD_DR : ST_PA_DR;
			end
			ST_PA_DR: begin
				state_nxt = tms_eff ? ST_EX2_DR : ST_PA_DR;
			end
			ST_EX2_DR: begin
				state_nxt = tms_eff ? ST_UPD_DR : ST_SH_DR;
			end
			ST_UPD_DR: begin
				state_nxt = tms_eff ? ST_SEL_DR : ST_RTI;
			end
			ST_SEL_IR: begin
				// mode select high here walks into reset, part of the five-edge escape
				state_nxt = tms_eff ? ST_TLR : ST_CAP_IR;
			end
			ST_CAP_IR: begin
				state_nxt = tms_eff ? ST_EX1_IR : ST_SH_IR;
			end
			ST_SH_IR: begin
				state_nxt = tms_eff ? ST_EX1_IR : ST_SH_IR;
			end
			ST_EX1_IR: begin
				state_nxt = tms_eff ? ST_UPD_IR : ST_PA_IR;
			end
			ST_PA_IR: begin
				state_nxt = tms_eff ? ST_EX2_IR : ST_PA_IR;
			end
			ST_EX2_IR: begin
				state_nxt = tms_eff ? ST_UPD_IR : ST_SH_IR;
			end
			ST_UPD_IR: begin
				state_nxt = tms_eff ? ST_SEL_DR : ST_RTI;
			end
			default: begin
				// an illegal code recovers through reset
				state_nxt = ST_TLR;
			end
		endcase
	end

	// controller register; power-up reset puts it in test reset
	always_ff @(posedge test_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			state_r <= ST_TLR;
		end else begin
			state_r <= state_nxt;
		end
	end

	logic [IR_W-1:0] ir_sh_r; // instruction shift stage
	logic [IR_W-1:0] ir_sh_nxt;
	logic [IR_W-1:0] ir_r; // instruction in force
	logic [IR_W-1:0] ir_nxt;

	// instruction register next values
	always_comb begin
		ir_sh_nxt = ir_sh_r;
		ir_nxt = ir_r;
		if (state_r == ST_CAP_IR) begin
			ir_sh_nxt = IR_CAPT;
		end else if (state_r == ST_SH_IR) begin
			ir_sh_nxt = {tdi_eff, ir_sh_r[IR_W-1:1]};
		end
		if (state_r == ST_TLR) begin
			ir_nxt = IR_IDCODE;
		end else if (state_r == ST_UPD_IR) begin
			ir_nxt = ir_sh_r;
		end
	end

	// instruction registers
	always_ff @(posedge test_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			ir_sh_r <= IR_CAPT;
			ir_r <= IR_IDCODE;
		end else begin
			ir_sh_r <= ir_sh_nxt;
			ir_r <= ir_nxt;
		end
	end
	assign ir_o = ir_r;

	logic sel_id; // identification register is selected
	assign sel_id = (ir_r == IR_IDCODE);

	logic [ID_W-1:0] id_sh_r; // identification shift register
	logic [ID_W-1:0] id_sh_nxt;
	logic byp_r; // bypass cell
	logic byp_nxt;

	// data register next values; instructions other than identify use the bypass
	// cell, since no boundary ring is built here
	always_comb begin
		id_sh_nxt = id_sh_r;
		byp_nxt = byp_r;
		if (state_r == ST_CAP_DR) begin
			if (sel_id) begin
				id_sh_nxt = ID_VALUE;
			end else begin
				byp_nxt = BYP_CAPT[0];
			end
		end else if (state_r == ST_SH_DR) begin
			if (sel_id) begin
				id_sh_nxt = {tdi_eff, id_sh_r[ID_W-1:1]};
			end else begin
				byp_nxt = tdi_eff;
			end
		end
	end

	// data registers
	always_ff @(posedge test_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			id_sh_r <= ID_VALUE;
			byp_r <= BYP_CAPT[0];
		end else begin
			id_sh_r <= id_sh_nxt;
			byp_r <= byp_nxt;
		end
	end

	logic tdo_r; // output bit, falling-edge register
	logic tdo_nxt;
	logic tdo_oe_r; // output enable, falling-edge register
	logic tdo_oe_nxt;

	// output selection; the low bit of the selected register leaves first
	always_comb begin
		tdo_oe_nxt = (state_r == ST_SH_DR) || (state_r == ST_SH_IR);
		if (state_r == ST_SH_IR) begin
			tdo_nxt = ir_sh_r[0];
		end else if (sel_id) begin
			tdo_nxt = id_sh_r[0];
		end else begin
			tdo_nxt = byp_r;
		end
	end

	// falling edge gives the board a half period of setup at its rising edge
	always_ff @(negedge test_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			tdo_r <= 1'b0;
			tdo_oe_r <= 1'b0;
		end else begin
			tdo_r <= tdo_nxt;
			tdo_oe_r <= tdo_oe_nxt;
		end
	end
	assign tdo_o = tdo_r;
	assign tdo_oe_o = tdo_oe_r;

	// test reset level toward the core; nothing in the core acts on it, so the
	// memory runs on untouched whatever the port does
	logic tlr_r; // test reset level in test clock domain
	logic tlr_nxt;
	assign tlr_nxt = (state_nxt == ST_TLR);
	always_ff @(posedge test_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			tlr_r <= 1'b1;
		end else begin
			tlr_r <= tlr_nxt;
		end
	end

	logic [SYNC_N-1:0] sync_r; // three-flop synchroniser
	logic [SYNC_N-1:0] sync_nxt;
	logic rst_lvl_r; // filtered level, changes when stages two and three agree
	logic rst_lvl_nxt;

	// crossing into the core clock; only stage two reads stage one
	always_comb begin
		sync_nxt = {sync_r[SYNC_N-2:0], tlr_r};
		rst_lvl_nxt = rst_lvl_r;
		if (sync_r[1] == sync_r[2]) begin
			rst_lvl_nxt = sync_r[2];
		end
	end

	always_ff @(posedge core_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			sync_r <= '1;
			rst_lvl_r <= 1'b1;
		end else begin
			sync_r <= sync_nxt;
			rst_lvl_r <= rst_lvl_nxt;
		end
	end
	assign tap_reset_o = rst_lvl_r;

	// checks on the test clock
	property p_five_reset;
		@(posedge test_clk_i) disable iff (!nrst_i)
		tms_eff [*5] |=> (state_r == ST_TLR);
	endproperty
	a_five_reset: assert property (p_five_reset) else $error("no reset after five highs");

	property p_ir_reset;
		@(posedge test_clk_i) disable iff (!nrst_i)
		(state_r == ST_TLR) |=> (ir_r == IR_IDCODE);
	endproperty
	a_ir_reset: assert property (p_ir_reset) else $error("reset left no identify");

	property p_ir_update;
		@(posedge test_clk_i) disable iff (!nrst_i)
		(state_r == ST_UPD_IR) |=> (ir_r == $past(ir_sh_r));
	endproperty
	a_ir_update: assert property (p_ir_update) else $error("instruction not updated");

	property p_ir_capt;
		@(posedge test_clk_i) disable iff (!nrst_i)
		(state_r == ST_CAP_IR) |=> (ir_sh_r[1:0] == 2'b01);
	endproperty
	a_ir_capt: assert property (p_ir_capt) else $error("capture pattern wrong");

	property p_id_capt;
		@(posedge test_clk_i) disable iff (!nrst_i)
		(state_r == ST_CAP_DR && sel_id) |=> (id_sh_r == ID_VALUE);
	endproperty
	a_id_capt: assert property (p_id_capt) else $error("id code not captured");

	property p_msb_in;
		@(posedge test_clk_i) disable iff (!nrst_i)
		(state_r == ST_SH_DR && sel_id) |=> (id_sh_r[ID_W-1] == $past(tdi_eff));
	endproperty
	a_msb_in: assert property (p_msb_in) else $error("data in missed top bit");

	property p_bypass;
		@(posedge test_clk_i) disable iff (!nrst_i)
		(state_r == ST_SH_DR && !sel_id) |=> (byp_r == $past(tdi_eff));
	endproperty
	a_bypass: assert property (p_bypass) else $error("bypass cell not shifted");

	property p_oe;
		@(posedge test_clk_i) disable iff (!nrst_i)
		tdo_oe_o == (state_r == ST_SH_DR || state_r == ST_SH_IR);
	endproperty
	a_oe: assert property (p_oe) else $error("output enable outside shift");

	property p_lsb_out;
		@(posedge test_clk_i) disable iff (!nrst_i)
		(state_r == ST_SH_DR && sel_id) |-> (tdo_o == id_sh_r[0]);
	endproperty
	a_lsb_out: assert property (p_lsb_out) else $error("output not low bit");

	// a shift state left on mode select high drops the driver by the next edge
	property p_oe_off;
		@(posedge test_clk_i) disable iff (!nrst_i)
		(state_r == ST_SH_DR || state_r == ST_SH_IR) && tms_eff |=> !tdo_oe_o;
	endproperty
	a_oe_off: assert property (p_oe_off) else $error("output still driven after shift");

	property p_lsb_ir;
		@(posedge test_clk_i) disable iff (!nrst_i)
		(state_r == ST_SH_IR) |-> (tdo_o == ir_sh_r[0]);
	endproperty
	a_lsb_ir: assert property (p_lsb_ir) else $error("output not instruction low bit");

	property p_lsb_byp;
		@(posedge test_clk_i) disable iff (!nrst_i)
		(state_r == ST_SH_DR && !sel_id) |-> (tdo_o == byp_r);
	endproperty
	a_lsb_byp: assert property (p_lsb_byp) else $error("output not bypass cell");

	property p_id_shift;
		@(posedge test_clk_i) disable iff (!nrst_i)
		(state_r == ST_SH_DR && sel_id) |=> (id_sh_r[ID_W-2:0] == $past(id_sh_r[ID_W-1:1]));
	endproperty
	a_id_shift: assert property (p_id_shift) else $error("id code not shifted down");

	property p_ir_shift;
		@(posedge test_clk_i) disable iff (!nrst_i)
		(state_r == ST_SH_IR) |=> (ir_sh_r == {$past(tdi_eff), $past(ir_sh_r[IR_W-1:1])});
	endproperty
	a_ir_shift: assert property (p_ir_shift) else $error("instruction stage not shifted");

	property p_byp_capt;
		@(posedge test_clk_i) disable iff (!nrst_i)
		(state_r == ST_CAP_DR && !sel_id) |=> (byp_r == BYP_CAPT[0]);
	endproperty
	a_byp_capt: assert property (p_byp_capt) else $error("bypass cell not cleared");
endmodule : sbt_tap

/* File: bench/sbt_ctl.sv */
// board test controller model: test clock, mode select and data in
`timescale 1ns/10ps
module sbt_ctl (
	output logic tck_o, // test clock, low outside frames
	output logic tms_o, // mode select level
	output logic tms_drv_o, // high while mode select is driven
	output logic tdi_o, // serial data to the port
	output logic tdi_drv_o // high while data in is driven
);
	// the clock stands still low until a frame starts
	initial begin
		tck_o = 1'b0;
		tms_o = 1'b1;
		tms_drv_o = 1'b1;
		tdi_o = 1'b1;
		tdi_drv_o = 1'b1;
	end
	// one 80 ns test clock period; lines move only while the clock is low
	task step(input logic m, input logic d, input logic flt);
		tms_drv_o = ~flt;
		tdi_drv_o = ~flt;
		tms_o = flt ? ~tms_o : m; // a released line must not show a stale level
		tdi_o = flt ? ~tdi_o : d;
		#20 tck_o = 1'b1;
		#40 tck_o = 1'b0;
		#20;
	endtask : step
endmodule : sbt_ctl

/* File: bench/sbt_tap_test.sv */
// self-checking bench for the memory test access port
`timescale 1ns/10ps
module sbt_tap_test;
	import sbt_pkg::*;
	logic core_clk = 1'b0; // core clock, 100 MHz
	logic nrst_n = 1'b0; // power-up reset, active low
	logic tck, tms, tms_drv, tdi, tdi_drv; // board side lines
	logic tdo, tdo_oe, tap_reset; // port outputs
	logic [IR_W-1:0] ir; // current instruction
	logic [2:0] notes[$]; // care, enable, data per test clock edge
	logic [2:0] nt; // note under comparison
	logic [1:0] sv; // output level at the rising edge
	logic [31:0] rng = 32'h0001_840F; // xorshift state, seed 99343
	logic [31:0] d; // random shift data
	int failures = 0;
	int tests_run = 0;
	always #5 core_clk = ~core_clk;
	sbt_ctl u_ctl (.tck_o(tck), .tms_o(tms), .tms_drv_o(tms_drv), .tdi_o(tdi),
		.tdi_drv_o(tdi_drv));
	sbt_tap u_dut (.core_clk_i(core_clk), .nrst_i(nrst_n), .test_clk_i(tck), .tms_i(tms),
		.tms_drv_i(tms_drv), .tdi_i(tdi), .tdi_drv_i(tdi_drv), .tdo_o(tdo),
		.tdo_oe_o(tdo_oe), .ir_o(ir), .tap_reset_o(tap_reset));
	function logic [31:0] xorshift();
		rng = rng ^ (rng << 13);
		rng = rng ^ (rng >> 17);
		rng = rng ^ (rng << 5);
		return rng;
	endfunction : xorshift
	task check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		tests_run++;
		if (seen !== exp) begin
			failures++;
			$display("unexpected %s: expected %h, seen %h", what, exp, seen);
		end
	endtask : check
	task end_of_test();
		$display("checks %0d, mismatches %0d", tests_run, failures);
		if (failures == 0 && tests_run > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask : end_of_test
	// note what the next edge should see, then clock it
	task tstep(input logic m, input logic dd, input logic care, input logic [1:0] ex,
		input logic flt = 1'b0);
		notes.push_back({care, ex});
		u_ctl.step(m, dd, flt);
	endtask : tstep
	// walk the controller with a mode select list, lowest bit first
	task go(input logic [7:0] seq, input int n);
		for (int i = 0; i < n; i++) tstep(seq[i], 1'b0, 1'b1, 2'b00);
	endtask : go
	// shift n bits in from a shift state, then update and park in idle
	task shift(input int n, input logic [31:0] din, input logic [31:0] exp);
		for (int i = 0; i < n; i++) tstep(i == n - 1, din[i], 1'b1, {1'b1, exp[i]});
		tstep(1'b1, 1'b0, 1'b1, 2'b00);
		tstep(1'b0, 1'b0, 1'b1, 2'b00);
	endtask : shift
	// oldest note is judged at every test clock rising edge
	always @(posedge tck) begin
		nt = notes.pop_front();
		sv = {tdo_oe, tdo};
		if (nt[2]) begin
			check("tdo_oe", tdo_oe, nt[1]);
			if (nt[1]) check("tdo", tdo, nt[0]);
		end
		#30 check("output between edges", {tdo_oe, tdo}, sv);
	end
	// cut a hang short; the run needs about 25 us
	initial begin
		#300000;
		failures++;
		end_of_test();
	end
	// main sequence
	initial begin
		tstep(1'b1, 1'b1, 1'b0, 2'b00); // test clock edge inside reset
		repeat (16) @(posedge core_clk);
		#1 nrst_n = 1'b1;
		check("ir after power up", ir, IR_IDCODE);
		check("tap_reset after power up", tap_reset, 1'b1);
		check("tdo_oe after power up", tdo_oe, 1'b0);
		go(8'h02, 4);
		check("tap_reset in use", tap_reset, 1'b0);
		shift(32, xorshift(), ID_VALUE);
		for (int c = 0; c < 8; c++) begin
			go(8'h03, 4);
			shift(3, c, IR_CAPT);
			check("instruction", ir, c[2:0]);
			go(8'h01, 3);
			d = xorshift();
			if (c[2:0] == IR_IDCODE) shift(32, d, ID_VALUE);
			else shift(8, d, {d[30:0], BYP_CAPT});
		end
		// floated pins read high, five edges reset the port
		for (int i = 0; i < 5; i++) tstep(1'b0, 1'b0, 1'b1, 2'b00, 1'b1);
		check("tap_reset after five edges", tap_reset, 1'b1);
		check("ir after test reset", ir, IR_IDCODE);
		go(8'h06, 5);
		shift(3, IR_BYPASS, IR_CAPT);
		check("instruction", ir, IR_BYPASS);
		@(posedge core_clk) #1 nrst_n = 1'b0;
		tstep(1'b0, 1'b0, 1'b0, 2'b00);
		check("ir in mid-run reset", ir, IR_IDCODE);
		check("tdo_oe in mid-run reset", tdo_oe, 1'b0);
		check("tap_reset in mid-run reset", tap_reset, 1'b1);
		@(posedge core_clk) #1 nrst_n = 1'b1;
		// the port must work again straight after a mid-run reset
		go(8'h02, 4);
		check("tap_reset after restart", tap_reset, 1'b0);
		shift(32, xorshift(), ID_VALUE);
		end_of_test();
	end
endmodule : sbt_tap_test
